// ### rtl/sbcpc_checker.sv
// Control packet checker, retry filter and notification builder.
// Assumes parsed headers arrive as one-cycle strobes from the receive path
// and that a command executor on mclk answers each exec_start once.
`timescale 1ns/10ps
module sbcpc_checker
  import sbcpc_pkg::*;
#(
  parameter int t5_us = 50
) (
  input  wire logic                     mclk,
  input  wire logic                     reset,
  input  wire logic                     rx_valid,
  input  wire sbcpc_rx_t                rx_hdr,
  input  wire logic [7:0]               own_ch_id,
  input  wire logic                     init_entry,
  input  wire logic                     exec_done,
  input  wire logic [15:0]              exec_code,
  input  wire logic [15:0]              exec_reason,
  input  wire logic                     aen_en_wr,
  input  wire logic [SBCPC_NUM_EVT-1:0] aen_en_mask,
  input  wire logic [7:0]               aen_en_mc_id,
  input  wire logic                     aen_en_rbt,
  input  wire logic                     rbt_active_pin,
  input  wire logic [SBCPC_NUM_EVT-1:0] evt,
  output logic                          drop,
  output sbcpc_drop_t                   drop_why,
  output logic                          exec_start,
  output sbcpc_rx_t                     exec_cmd,
  output logic                          rsp_valid,
  output sbcpc_rsp_t                    rsp,
  output logic                          aen_valid,
  output sbcpc_aen_t                    aen,
  output logic                          pt_tx_stop,
  output logic                          busy
);

  // Longest wait, so it rounds down.
  localparam int T5_CYC = (t5_us * 1000) / SBCPC_CLK_NS;

  typedef struct packed {
    sbcpc_st_t                st;
    logic [31:0]              cnt;
    logic                     late;
    logic                     last_ok;
    logic [7:0]               last_iid;
    sbcpc_rsp_t               last_rsp;
    logic [SBCPC_NUM_EVT-1:0] en;
    logic                     en_rbt;
    logic [7:0]               mc_id;
    logic [SBCPC_NUM_EVT-1:0] pend;
    logic                     drop;
    sbcpc_drop_t              drop_why;
    logic                     exec_start;
    sbcpc_rx_t                exec_cmd;
    logic                     rsp_valid;
    sbcpc_rsp_t               rsp;
    logic                     aen_valid;
    sbcpc_aen_t               aen;
    logic                     pt_tx_stop;
    logic                     busy;
  } sbcpc_state_t;

  sbcpc_state_t s;
  sbcpc_state_t next_s;
  logic         rbt_active;

  function automatic logic [7:0] first_set(
    input logic [SBCPC_NUM_EVT-1:0] v
  );
    logic [7:0] idx;
    idx = 8'h00;
    for (int i = SBCPC_NUM_EVT - 1; i >= 0; i--)
      if (v[i])
        idx = 8'(i);
    return idx;
  endfunction

  function automatic logic [7:0] evt_code(input logic [7:0] idx);
    logic [7:0] code;
    case (idx)
      8'h00:   code = SBCPC_EVT_LINK;
      8'h01:   code = SBCPC_EVT_CFG;
      8'h02:   code = SBCPC_EVT_DRV;
      8'h03:   code = SBCPC_EVT_DLY;
      8'h04:   code = SBCPC_EVT_PLDM;
      default: code = SBCPC_EVT_SPDM;
    endcase
    return code;
  endfunction

  sbcpc_sync2 u_rbt_sync (
    .mclk  (mclk),
    .reset (reset),
    .d     (rbt_active_pin),
    .q     (rbt_active)
  );

  logic                     medium_ok;
  logic                     is_retry;
  logic                     len_bad;
  logic [SBCPC_NUM_EVT-1:0] sent;
  logic [7:0]               pick;

  always_comb
  begin
    next_s            = s;
    next_s.drop       = 1'b0;
    next_s.drop_why   = SBCPC_DROP_NONE;
    next_s.exec_start = 1'b0;
    next_s.rsp_valid  = 1'b0;
    next_s.aen_valid  = 1'b0;
    next_s.pt_tx_stop = init_entry;
    sent      = '0;
    pick      = first_set(s.pend);
    medium_ok = s.en_rbt & rbt_active;
    // Oversized OEM commands are a build-time option.
    len_bad   = !rx_hdr.len_ok &&
                !(SBCPC_OEM_BIG && rx_hdr.oem && rx_hdr.oversize);
    is_retry  = s.last_ok && rx_hdr.iid == s.last_iid;

    if (aen_en_wr)
    begin
      next_s.en     = aen_en_mask;
      next_s.en_rbt = aen_en_rbt;
      next_s.mc_id  = aen_en_mc_id;
    end

    if (s.st == SBCPC_EXEC)
    begin
      next_s.cnt = s.cnt + 32'd1;
      if (exec_done)
      begin
        next_s.st       = SBCPC_IDLE;
        next_s.last_rsp = '{iid: s.exec_cmd.iid, cmd: s.exec_cmd.cmd,
                            code: exec_code, reason: exec_reason};
        next_s.last_ok  = 1'b1;
        next_s.last_iid = s.exec_cmd.iid;
        // After a delayed answer the late result is kept for the retry.
        next_s.rsp_valid = !s.late;
        next_s.rsp       = next_s.last_rsp;
      end
      else if (!s.late && s.cnt == 32'(T5_CYC - 1))
      begin
        next_s.late      = 1'b1;
        next_s.rsp_valid = 1'b1;
        next_s.rsp       = '{iid: s.exec_cmd.iid, cmd: s.exec_cmd.cmd,
                             code: SBCPC_RC_DELAY, reason: SBCPC_RS_SLOW};
      end
    end

    if (rx_valid)
    begin
      next_s.drop = 1'b1;
      if (init_entry)
        next_s.drop_why = SBCPC_DROP_INIT;
      else if (!rx_hdr.fcs_ok)
        next_s.drop_why = SBCPC_DROP_FCS;
      else if (len_bad)
        next_s.drop_why = SBCPC_DROP_LEN;
      else if (rx_hdr.csum_present && !rx_hdr.csum_ok)
        next_s.drop_why = SBCPC_DROP_CSUM;
      else if (rx_hdr.ch_id != own_ch_id)
        next_s.drop_why = SBCPC_DROP_CHID;
      else if (rx_hdr.hdr_rev != SBCPC_HDR_REV)
        next_s.drop_why = SBCPC_DROP_REV;
      else if (s.st == SBCPC_EXEC || s.rsp_valid)
        next_s.drop_why = SBCPC_DROP_BUSY;
      else if (is_retry)
      begin
        // Replaying the stored answer keeps retries free of side effects.
        next_s.drop      = 1'b0;
        next_s.rsp_valid = 1'b1;
        next_s.rsp       = s.last_rsp;
      end
      else
      begin
        next_s.drop       = 1'b0;
        next_s.exec_start = 1'b1;
        next_s.exec_cmd   = rx_hdr;
        next_s.st         = SBCPC_EXEC;
        next_s.cnt        = '0;
        next_s.late       = 1'b0;
      end
    end

    // Responses take the transmit slot first; a notification waits a cycle.
    if (!next_s.rsp_valid && s.pend != '0 && medium_ok)
    begin
      sent[pick[2:0]]  = 1'b1;
      next_s.aen_valid = 1'b1;
      next_s.aen       = '{aen_type: evt_code(pick),
                           ch_id: own_ch_id,
                           iid: SBCPC_AEN_IID,
                           mc_id: s.mc_id};
    end
    // New events win over the slot that is being emptied.
    next_s.pend = ((s.pend & ~sent) | evt) & next_s.en;
    if (!medium_ok)
      next_s.pend = '0;

    if (init_entry)
    begin
      next_s.st      = SBCPC_IDLE;
      next_s.last_ok = 1'b0;
      next_s.en      = '0;
      next_s.pend    = '0;
    end
    // Busy has its own flop so the port comes straight from a register.
    next_s.busy = (next_s.st == SBCPC_EXEC);
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s            <= '0;
      s.st         <= SBCPC_IDLE;
      s.pt_tx_stop <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign drop       = s.drop;
  assign drop_why   = s.drop_why;
  assign exec_start = s.exec_start;
  assign exec_cmd   = s.exec_cmd;
  assign rsp_valid  = s.rsp_valid;
  assign rsp        = s.rsp;
  assign aen_valid  = s.aen_valid;
  assign aen        = s.aen;
  assign pt_tx_stop = s.pt_tx_stop;
  assign busy       = s.busy;

  property p_bad_fcs_drop;
    @(posedge mclk) disable iff (reset)
    rx_valid && !init_entry && !rx_hdr.fcs_ok
      |=> drop && drop_why == SBCPC_DROP_FCS && !exec_start;
  endproperty
  a_bad_fcs_drop: assert property (p_bad_fcs_drop)
    else $error("bad frame check not dropped");

  property p_chid_drop;
    @(posedge mclk) disable iff (reset)
    rx_valid && !init_entry && rx_hdr.fcs_ok && !len_bad &&
      !(rx_hdr.csum_present && !rx_hdr.csum_ok) &&
      rx_hdr.ch_id != own_ch_id
      |=> drop && drop_why == SBCPC_DROP_CHID;
  endproperty
  a_chid_drop: assert property (p_chid_drop)
    else $error("foreign channel packet not dropped");

  property p_busy_drop;
    @(posedge mclk) disable iff (reset)
    busy && rx_valid |=> !exec_start;
  endproperty
  a_busy_drop: assert property (p_busy_drop)
    else $error("command started while busy");

  function automatic logic drop_cond();
    return init_entry || !rx_hdr.fcs_ok || len_bad ||
           (rx_hdr.csum_present && !rx_hdr.csum_ok) ||
           rx_hdr.ch_id != own_ch_id || rx_hdr.hdr_rev != SBCPC_HDR_REV;
  endfunction

  property p_retry_replay;
    @(posedge mclk) disable iff (reset)
    rx_valid && !drop_cond() && is_retry && !busy && !rsp_valid
      |=> rsp_valid && !exec_start && rsp == $past(s.last_rsp);
  endproperty
  a_retry_replay: assert property (p_retry_replay)
    else $error("retry did not replay stored response");

  property p_aen_header;
    @(posedge mclk) disable iff (reset)
    aen_valid |-> aen.iid == SBCPC_AEN_IID && aen.mc_id == $past(s.mc_id);
  endproperty
  a_aen_header: assert property (p_aen_header)
    else $error("notification header fields wrong");

  property p_aen_chid;
    @(posedge mclk) disable iff (reset)
    aen_valid |-> aen.ch_id == $past(own_ch_id);
  endproperty
  a_aen_chid: assert property (p_aen_chid)
    else $error("notification channel field wrong");

  property p_aen_enabled;
    @(posedge mclk) disable iff (reset)
    aen_valid |-> $past(s.en_rbt) && $past(rbt_active);
  endproperty
  a_aen_enabled: assert property (p_aen_enabled)
    else $error("notification sent on inactive medium");

  property p_no_cache;
    @(posedge mclk) disable iff (reset)
    !rbt_active ##1 rbt_active |=> !aen_valid;
  endproperty
  a_no_cache: assert property (p_no_cache)
    else $error("suppressed notification was replayed");

  property p_t5_answer;
    @(posedge mclk) disable iff (reset || init_entry)
    busy && !s.late && !exec_done && s.cnt == 32'(T5_CYC - 1)
      |=> rsp_valid && rsp.code != SBCPC_RC_OK;
  endproperty
  a_t5_answer: assert property (p_t5_answer)
    else $error("no answer within execution interval");

  property p_init_stop;
    @(posedge mclk) disable iff (reset)
    init_entry |=> pt_tx_stop && !exec_start;
  endproperty
  a_init_stop: assert property (p_init_stop)
    else $error("pass-through not stopped in initial state");

  property p_pend_enabled;
    @(posedge mclk) disable iff (reset)
    (s.pend & ~s.en) == '0;
  endproperty
  a_pend_enabled: assert property (p_pend_enabled)
    else $error("pending notification of a disabled type");

  property p_exec_rsp;
    @(posedge mclk) disable iff (reset)
    busy && exec_done && !s.late
      |=> rsp_valid && rsp.code == $past(exec_code) &&
          rsp.reason == $past(exec_reason);
  endproperty
  a_exec_rsp: assert property (p_exec_rsp)
    else $error("executor result not returned in response");

  property p_late_silent;
    @(posedge mclk) disable iff (reset)
    busy && exec_done && s.late |=> !rsp_valid;
  endproperty
  a_late_silent: assert property (p_late_silent)
    else $error("late result sent without a retry");

  property p_init_forget;
    @(posedge mclk) disable iff (reset)
    init_entry |=> !s.last_ok && s.en == '0;
  endproperty
  a_init_forget: assert property (p_init_forget)
    else $error("retry state kept across initial state");

endmodule // sbcpc_checker

// ### rtl/sbcpc_pkg.sv
// Shared types and constants for the sideband control packet checker.
// Assumes one management channel per instance, clocked by mclk at 125 MHz.
package sbcpc_pkg;

  localparam int          SBCPC_CLK_NS   = 8;
  localparam int          SBCPC_NUM_EVT  = 6;
  localparam logic [7:0]  SBCPC_HDR_REV  = 8'h01;
  localparam logic [7:0]  SBCPC_AEN_IID  = 8'h00;
  localparam logic        SBCPC_OEM_BIG  = 1'b1;

  localparam logic [7:0]  SBCPC_EVT_LINK = 8'h00;
  localparam logic [7:0]  SBCPC_EVT_CFG  = 8'h01;
  localparam logic [7:0]  SBCPC_EVT_DRV  = 8'h02;
  localparam logic [7:0]  SBCPC_EVT_DLY  = 8'h03;
  localparam logic [7:0]  SBCPC_EVT_PLDM = 8'h04;
  localparam logic [7:0]  SBCPC_EVT_SPDM = 8'h05;

  localparam logic [15:0] SBCPC_RC_OK    = 16'h0000;
  localparam logic [15:0] SBCPC_RC_DELAY = 16'h0004;
  localparam logic [15:0] SBCPC_RS_NONE  = 16'h0000;
  localparam logic [15:0] SBCPC_RS_SLOW  = 16'h0001;

  typedef enum logic [2:0] {
    SBCPC_DROP_NONE,
    SBCPC_DROP_INIT,
    SBCPC_DROP_FCS,
    SBCPC_DROP_LEN,
    SBCPC_DROP_CSUM,
    SBCPC_DROP_CHID,
    SBCPC_DROP_REV,
    SBCPC_DROP_BUSY
  } sbcpc_drop_t;

  typedef enum logic {SBCPC_IDLE, SBCPC_EXEC} sbcpc_st_t;

  typedef struct packed {
    logic       fcs_ok;
    logic       len_ok;
    logic       oversize;
    logic       oem;
    logic       csum_present;
    logic       csum_ok;
    logic [7:0] ch_id;
    logic [7:0] hdr_rev;
    logic [7:0] iid;
    logic [7:0] cmd;
  } sbcpc_rx_t;

  typedef struct packed {
    logic [7:0]  iid;
    logic [7:0]  cmd;
    logic [15:0] code;
    logic [15:0] reason;
  } sbcpc_rsp_t;

  typedef struct packed {
    logic [7:0] aen_type;
    logic [7:0] ch_id;
    logic [7:0] iid;
    logic [7:0] mc_id;
  } sbcpc_aen_t;

endpackage

// ### rtl/sbcpc_sync2.sv
// Two-stage synchroniser for one asynchronous level.
// Assumes the level is slow compared with mclk.
`timescale 1ns/10ps
module sbcpc_sync2 (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic d,
  output logic      q
);

  typedef struct packed {
    logic meta;
    logic stable;
  } sbcpc_sync_t;

  sbcpc_sync_t s;
  sbcpc_sync_t next_s;

  always_comb
  begin
    next_s.meta   = d;
    next_s.stable = s.meta;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      s <= '0;
    else
      s <= next_s;
  end

  assign q = s.stable;

endmodule // sbcpc_sync2

// ### verification/sbcpc_exec_model.sv
// Behavioural command executor that answers each exec_start once.
// Assumes delay and code_in are set by the bench before each command.
`timescale 1ns/10ps
module sbcpc_exec_model (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        exec_start,
  input  wire logic [15:0] delay,
  input  wire logic [15:0] code_in,
  output logic             exec_done,
  output logic [15:0]      exec_code,
  output logic [15:0]      exec_reason
);
  logic [15:0] left = '0;

  initial
  begin
    exec_done = 1'b0;
    exec_code = 16'h0000;
    exec_reason = 16'h0000;
  end

  // Result lines toggle outside the done pulse so a stale value is never seen.
  always @(posedge mclk)
  begin
    exec_done <= 1'b0;
    exec_code <= ~exec_code;
    exec_reason <= ~exec_reason;
    if (reset)
      left <= '0;
    else if (exec_start)
      left <= delay;
    else if (left == 16'h0001)
    begin
      left <= '0;
      exec_done <= 1'b1;
      exec_code <= code_in;
      exec_reason <= 16'h0000;
    end
    else if (left != 16'h0000)
      left <= left - 16'h0001;
  end
endmodule // sbcpc_exec_model

// ### verification/tb_top.sv
// Self-checking bench for the control packet checker.
// Assumes t5_us of 1, so the execution limit is 125 cycles of mclk.
`timescale 1ns/10ps
module tb_top;
  import sbcpc_pkg::*;
  localparam logic [7:0] own_ch = 8'h02;
  logic        mclk, reset, rx_valid, init_entry, exec_done, aen_en_wr;
  logic        aen_en_rbt, rbt_active_pin, drop, exec_start, rsp_valid;
  logic        aen_valid, pt_tx_stop, busy;
  logic [15:0] exec_code, exec_reason, delay, code_in;
  logic [5:0]  aen_en_mask, evt;
  logic [7:0]  aen_en_mc_id;
  sbcpc_rx_t   rx_hdr, exec_cmd;
  sbcpc_drop_t drop_why;
  sbcpc_rsp_t  rsp;
  sbcpc_aen_t  aen;
  int          n_errors = 0, check_count = 0, waited;

  sbcpc_checker #(.t5_us(1)) uut (.mclk, .reset, .rx_valid, .rx_hdr,
    .own_ch_id(own_ch), .init_entry, .exec_done, .exec_code, .exec_reason,
    .aen_en_wr, .aen_en_mask, .aen_en_mc_id, .aen_en_rbt, .rbt_active_pin,
    .evt, .drop, .drop_why, .exec_start, .exec_cmd, .rsp_valid, .rsp,
    .aen_valid, .aen, .pt_tx_stop, .busy);
  sbcpc_exec_model model (.mclk, .reset, .exec_start, .delay, .code_in,
    .exec_done, .exec_code, .exec_reason);

  always #4 mclk = ~mclk;

  task automatic results;
    if (n_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic sig(input int w);
    case (w)
      0: return drop;
      1: return exec_start;
      2: return rsp_valid;
      default: return aen_valid;
    endcase
  endfunction

  // Bounded wait for an output pulse; a miss ends the run.
  task automatic wait_out(input int w, input int lim);
    waited = 0;
    #1;
    while (sig(w) !== 1'b1)
    begin
      if (waited == lim)
      begin
        chk(0, 1);
        results;
      end
      @(posedge mclk);
      #1;
      waited++;
    end
  endtask

  task automatic quiet(input int w, input int n);
    repeat (n)
    begin
      @(posedge mclk);
      #1;
      chk(sig(w), 0);
    end
  endtask

  function automatic sbcpc_rx_t mk(input logic [7:0] iid, input logic [7:0] c);
    return '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, own_ch, SBCPC_HDR_REV, iid, c};
  endfunction

  task automatic send(input sbcpc_rx_t h, input int w);
    @(posedge mclk);
    rx_valid <= 1'b1;
    rx_hdr <= h;
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_hdr <= ~h;
    wait_out(w, 3);
    chk({drop, exec_start, rsp_valid}, 3'b100 >> w);
  endtask

  task automatic en(input logic [5:0] m, input logic r);
    @(posedge mclk);
    aen_en_wr <= 1'b1;
    aen_en_mask <= m;
    aen_en_mc_id <= 8'h5a;
    aen_en_rbt <= r;
    @(posedge mclk);
    aen_en_wr <= 1'b0;
  endtask

  task automatic fire(input logic [5:0] v);
    @(posedge mclk);
    evt <= v;
    @(posedge mclk);
    evt <= '0;
  endtask

  task automatic t_drops;
    sbcpc_rx_t h;
    sbcpc_drop_t why [6] = '{SBCPC_DROP_FCS, SBCPC_DROP_LEN, SBCPC_DROP_CSUM,
      SBCPC_DROP_CHID, SBCPC_DROP_REV, SBCPC_DROP_FCS};
    for (int i = 0; i < 6; i++)
    begin
      h = mk(8'h20, 8'h01);
      case (i)
        0: h.fcs_ok = 1'b0;
        1: h.len_ok = 1'b0;
        2: h.csum_ok = 1'b0;
        3: h.ch_id = ~own_ch;
        4: h.hdr_rev = ~SBCPC_HDR_REV;
        default: {h.fcs_ok, h.ch_id} = {1'b0, ~own_ch};
      endcase
      send(h, 0);
      chk(drop_why, why[i]);
    end
    // Oversized OEM command without checksum must still be taken.
    h = mk(8'h21, 8'h50);
    {h.len_ok, h.oversize, h.oem, h.csum_present, h.csum_ok} = 5'b01100;
    send(h, 1);
    wait_out(2, 10);
  endtask

  task automatic t_exec;
    sbcpc_rx_t h = mk(8'h31, 8'h0b);
    delay = 16'd20;
    code_in = 16'h0003;
    send(h, 1);
    chk(exec_cmd, h);
    chk(busy, 1);
    send(mk(8'h32, 8'h0b), 0);
    chk(drop_why, SBCPC_DROP_BUSY);
    wait_out(2, 25);
    chk(rsp, {8'h31, 8'h0b, 16'h0003, SBCPC_RS_NONE});
    chk(busy, 0);
    send(h, 2);
    chk(rsp, {8'h31, 8'h0b, 16'h0003, SBCPC_RS_NONE});
    repeat (2)
    begin
      send(h, 2);
      chk(rsp, {8'h31, 8'h0b, 16'h0003, SBCPC_RS_NONE});
    end
  endtask

  task automatic t_timeout;
    delay = 16'd200;
    code_in = SBCPC_RC_OK;
    send(mk(8'h41, 8'h0c), 1);
    wait_out(2, 140);
    chk(waited > 120, 1);
    chk(rsp, {8'h41, 8'h0c, SBCPC_RC_DELAY, SBCPC_RS_SLOW});
    quiet(2, 90);
    send(mk(8'h41, 8'h0c), 2);
    chk(rsp, {8'h41, 8'h0c, SBCPC_RC_OK, SBCPC_RS_NONE});
  endtask

  task automatic t_aen;
    en(6'h3f, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      fire(6'h01 << i);
      wait_out(3, 3);
      chk(aen, {i[7:0], own_ch, SBCPC_AEN_IID, 8'h5a});
      quiet(3, 4);
    end
    fire(6'h06);
    wait_out(3, 3);
    chk(aen.aen_type, SBCPC_EVT_CFG);
    @(posedge mclk);
    #1 chk({aen_valid, aen.aen_type}, {1'b1, SBCPC_EVT_DRV});
    en(6'h3e, 1'b1);
    fire(6'h01);
    quiet(3, 4);
    rbt_active_pin <= 1'b0;
    repeat (4) @(posedge mclk);
    fire(6'h02);
    quiet(3, 3);
    rbt_active_pin <= 1'b1;
    quiet(3, 6);
    fire(6'h02);
    wait_out(3, 3);
    chk(aen.aen_type, SBCPC_EVT_CFG);
    en(6'h3f, 1'b0);
    fire(6'h02);
    quiet(3, 4);
  endtask

  task automatic t_init;
    @(posedge mclk);
    init_entry <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk(pt_tx_stop, 1);
    send(mk(8'h51, 8'h01), 0);
    chk(drop_why, SBCPC_DROP_INIT);
    @(posedge mclk);
    init_entry <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk(pt_tx_stop, 0);
    // The old identifier now runs afresh, which shows the initial state.
    delay = 16'd3;
    send(mk(8'h41, 8'h0c), 1);
    wait_out(2, 10);
    chk(rsp, {8'h41, 8'h0c, SBCPC_RC_OK, SBCPC_RS_NONE});
  endtask

  initial
  begin
    mclk = 1'b0;
    reset = 1'b1;
    rx_valid = 1'b0;
    rx_hdr = '0;
    init_entry = 1'b0;
    aen_en_wr = 1'b0;
    aen_en_mask = '0;
    aen_en_mc_id = '0;
    aen_en_rbt = 1'b0;
    rbt_active_pin = 1'b1;
    evt = '0;
    delay = 16'd5;
    code_in = 16'h0000;
    repeat (15) @(posedge mclk);
    #1 chk({pt_tx_stop, drop, exec_start, rsp_valid, aen_valid}, 5'b10000);
    @(posedge mclk);
    reset <= 1'b0;
    t_drops;
    t_exec;
    t_timeout;
    t_aen;
    t_init;
    results;
  end
endmodule // tb_top
